// ### rtl/fplc_top.sv
// Flash program, verify, erase and lock control with APB status
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module fplc_top
	import fplc_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYC,
	parameter int unsigned SER_ERASE_CYCLES = SER_ERASE_CYC,
	parameter int unsigned PAR_HOLD_CYCLES = PAR_HOLD_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Programming pins
	input wire logic dev_rst,
	input wire logic par_enable,
	input wire logic external_access_pin,
	input wire fplc_msel_t msel,
	input wire logic prog_strobe_n,
	input wire logic [13:0] par_addr,
	input wire logic [7:0] par_din,
	output logic [7:0] par_dout,
	output logic par_dout_oe,
	output logic ready_busy_output,
	// Serial programming
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// Protection outputs to the core
	output logic table_read_block,
	output logic ext_exec_block
);
	// ==========================================================
	// State
	logic [7:0] mem [0:CODE_BYTES-1];
	logic [2:0] lock_q;
	logic fuse_q, ea_latch_q, ser_en_q, exec_ext_q;
	fplc_op_t op_q;
	logic [TW-1:0] tmr_q, hold_q;
	logic [13:0] sweep_q, pend_addr_q;
	logic [7:0] pend_data_q;
	logic sweeping_q, strobe_q, sck_q;
	logic [23:0] sh_q;
	logic [4:0] bit_q;
	logic [7:0] out_q;
	logic [3:0] pm;
	logic busy, wr_block, rd_block, strobe_rise, sck_rise, sck_fall;
	logic [23:0] frame;
	logic par_go, ser_go, par_erase_go, ser_erase_go;
	fplc_op_t par_op;
	logic [7:0] code_rd_par;

	assign pm = msel;
	assign busy = (op_q != OP_IDLE);
	assign wr_block = lock_q[0];
	assign rd_block = lock_q[0] & lock_q[1];
	assign strobe_rise = prog_strobe_n & ~strobe_q;
	assign sck_rise = sck & ~sck_q;
	assign sck_fall = ~sck & sck_q;
	assign frame = {sh_q[22:0], mosi};

	// Byte seen at an address, with write-cycle polling
	function automatic logic [7:0] poll(input logic [13:0] a,
		input logic [7:0] v);
		if (op_q == OP_WRITE && a == pend_addr_q) begin
			poll = {~pend_data_q[7], pend_data_q[6:0]};
		end else if (a > CODE_LAST) begin
			poll = ERASED;
		end else begin
			poll = v;
		end
	endfunction : poll

	assign code_rd_par = poll(par_addr, mem[par_addr]);

	// ==========================================================
	// Parallel request decode
	always_comb begin
		par_op = OP_IDLE;
		unique case (pm)
			PM_WRITE: par_op = OP_WRITE;
			PM_WLOCK: par_op = OP_LOCK;
			PM_FUSE: par_op = OP_FUSE;
			default: par_op = OP_IDLE;
		endcase
	end
	// Writes refused under lock are dropped silently
	assign par_go = dev_rst & par_enable & strobe_rise & ~busy
		& (par_op == OP_FUSE || (par_op != OP_IDLE && !wr_block));
	assign par_erase_go = dev_rst & par_enable & ~busy & ~prog_strobe_n
		& (pm == PM_ERASE) & (hold_q == TW'(PAR_HOLD_CYCLES - 1));
	assign ser_go = dev_rst & ser_en_q & ~fuse_q & sck_rise
		& (bit_q == SI_LAST_BIT) & ~busy;
	assign ser_erase_go = ser_go & (frame[23:16] == SI_PREFIX)
		& (frame[10:8] == SI_ERASE);

	// ==========================================================
	// Strobe edge and erase hold timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_q <= 1'b1;
			hold_q <= '0;
		end else begin
			strobe_q <= prog_strobe_n;
			if (prog_strobe_n || pm != PM_ERASE || busy) begin
				hold_q <= '0;
			end else if (hold_q != TW'(PAR_HOLD_CYCLES - 1)) begin
				hold_q <= hold_q + TW'(1);
			end
		end
	end

	// ==========================================================
	// Serial shifter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_q <= 1'b0;
			sh_q <= '0;
			bit_q <= '0;
			out_q <= '0;
			miso <= 1'b0;
			ser_en_q <= 1'b0;
		end else begin
			sck_q <= sck;
			if (!dev_rst) begin
				bit_q <= '0;
				ser_en_q <= 1'b0;
				miso <= 1'b0;
			end else if (sck_rise) begin
				sh_q <= frame;
				bit_q <= (bit_q == SI_LAST_BIT) ? '0 : bit_q + 5'h1;
				if (bit_q == SI_LAST_BIT && frame[23:16] == SI_PREFIX
					&& frame[15:8] == SI_ENABLE && !fuse_q) begin
					ser_en_q <= 1'b1;
				end
				if (bit_q == SI_OUT_BIT - 5'h1) begin
					if (op_q == OP_ERASE) begin
						out_q <= ERASE_READ;
					end else if (rd_block || !ser_en_q || fuse_q) begin
						out_q <= ERASE_READ;
					end else begin
						out_q <= poll({frame[15:10], frame[7:0]},
							mem[{frame[15:10], frame[7:0]}]);
					end
				end
			end else if (sck_fall && bit_q >= SI_OUT_BIT) begin
				miso <= out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end

	// ==========================================================
	// Operation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q <= OP_IDLE;
			tmr_q <= '0;
			sweep_q <= '0;
			sweeping_q <= 1'b0;
			pend_addr_q <= '0;
			pend_data_q <= '0;
			lock_q <= '0;
			fuse_q <= 1'b0;
		end else begin
			unique case (op_q)
				OP_IDLE: begin
					if (par_erase_go || ser_erase_go) begin
						op_q <= OP_ERASE;
						sweeping_q <= 1'b1;
						sweep_q <= '0;
						tmr_q <= par_erase_go ? '0
							: TW'(SER_ERASE_CYCLES - 1);
					end else if (par_go) begin
						op_q <= par_op;
						tmr_q <= TW'(WRITE_CYCLES - 1);
						pend_addr_q <= par_addr;
						pend_data_q <= par_din;
					end else if (ser_go && !wr_block
						&& frame[17:16] == SI_WRITE) begin
						op_q <= OP_WRITE;
						tmr_q <= TW'(WRITE_CYCLES - 1);
						pend_addr_q <= {frame[23:18], frame[15:8]};
						pend_data_q <= frame[7:0];
					end else if (ser_go && !wr_block
						&& frame[23:16] == SI_PREFIX
						&& frame[10:8] == SI_WLOCK) begin
						op_q <= OP_LOCK;
						tmr_q <= TW'(WRITE_CYCLES - 1);
						pend_data_q <= frame[15:8];
					end
				end
				OP_ERASE: begin
					if (sweeping_q) begin
						sweep_q <= sweep_q + 14'h1;
						sweeping_q <= (sweep_q != CODE_LAST);
					end
					if (tmr_q != '0) begin
						tmr_q <= tmr_q - TW'(1);
					end else if (!sweeping_q) begin
						op_q <= OP_IDLE;
						lock_q <= '0;
					end
				end
				default: begin
					// Runs to the end without strobes
					if (tmr_q != '0) begin
						tmr_q <= tmr_q - TW'(1);
					end else begin
						op_q <= OP_IDLE;
						if (op_q == OP_LOCK) begin
							lock_q <= lock_q | {~pend_data_q[LB3_POS],
								~pend_data_q[LB2_POS],
								~pend_data_q[LB1_POS]};
						end
						if (op_q == OP_FUSE) begin
							fuse_q <= pend_data_q[0];
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Array writes; serial and parallel writes both replace the byte
	always_ff @(posedge pclk) begin
		if (op_q == OP_ERASE && sweeping_q) begin
			mem[sweep_q] <= ERASED;
		end else if (op_q == OP_WRITE && tmr_q == '0
			&& pend_addr_q <= CODE_LAST) begin
			mem[pend_addr_q] <= pend_data_q;
		end
	end

	// ==========================================================
	// Parallel readback and ready/busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_dout <= '0;
			par_dout_oe <= 1'b0;
			ready_busy_output <= 1'b1;
		end else begin
			ready_busy_output <= !(busy || par_go);
			par_dout_oe <= 1'b0;
			par_dout <= '0;
			// Lock readback is the one read mode with verify high
			if (dev_rst && par_enable
				&& (!msel.verify || pm == PM_RLOCK)) begin
				if (pm == PM_RLOCK) begin
					par_dout_oe <= 1'b1;
					par_dout[RLB1_POS] <= ~lock_q[0];
					par_dout[RLB2_POS] <= ~lock_q[1];
				end else if (pm == PM_SIG && (par_addr == SIG_ADDR0
					|| par_addr == SIG_ADDR1)) begin
					par_dout_oe <= 1'b1;
					par_dout <= (par_addr == SIG_ADDR0) ? SIG_BYTE0
						: SIG_BYTE1;
				end else if (pm == PM_READ && !rd_block) begin
					par_dout_oe <= 1'b1;
					par_dout <= code_rd_par;
				end
			end
		end
	end

	// ==========================================================
	// External access latch and core protection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ea_latch_q <= 1'b0;
			table_read_block <= 1'b0;
			ext_exec_block <= 1'b0;
		end else begin
			if (dev_rst && lock_q[0]) begin
				ea_latch_q <= external_access_pin;
			end
			table_read_block <= lock_q[0] & exec_ext_q;
			ext_exec_block <= &lock_q;
		end
	end

	// ==========================================================
	// APB slave: no wait states on any access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			exec_ext_q <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			if (psel && !penable) begin
				pslverr <= (paddr != REG_STATUS && paddr != REG_CTRL);
				prdata <= '0;
				if (!pwrite && paddr == REG_STATUS) begin
					prdata <= {24'h0, ser_en_q, fuse_q, ea_latch_q,
						op_q == OP_ERASE, busy, lock_q};
				end else if (!pwrite && paddr == REG_CTRL) begin
					prdata <= {31'h0, exec_ext_q};
				end
			end
			if (psel && penable && pready && pwrite
				&& paddr == REG_CTRL) begin
				exec_ext_q <= pwdata[0];
			end
		end
	end

	// ==========================================================
	// Checks
	a_write_locked: assert property (@(posedge pclk) disable iff (!presetn)
		lock_q[0] && op_q == OP_IDLE |=> op_q != OP_WRITE)
		else $error("write started under lock");
	a_verify_locked: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_block && pm == PM_READ |=> !par_dout_oe)
		else $error("verify visible under lock");
	a_exec_block: assert property (@(posedge pclk) disable iff (!presetn)
		(&lock_q) |=> ext_exec_block)
		else $error("external execution not blocked");
	a_lock_clear: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(lock_q[0]) |-> $past(op_q) == OP_ERASE)
		else $error("lock cleared outside erase");
	a_busy_line: assert property (@(posedge pclk) disable iff (!presetn)
		par_go |=> !ready_busy_output ##1 !ready_busy_output)
		else $error("ready line not low after strobe");
	a_poll_invert: assert property (@(posedge pclk)
		disable iff (!presetn)
		op_q == OP_WRITE && par_addr == pend_addr_q
		&& pm == PM_READ && !msel.verify && par_enable && dev_rst
		&& !rd_block ##1 op_q == OP_WRITE
		|-> par_dout[7] == ~pend_data_q[7])
		else $error("polling bit not inverted");
	a_erase_read: assert property (@(posedge pclk) disable iff (!presetn)
		op_q == OP_ERASE && sck_rise && bit_q == SI_OUT_BIT - 5'h1
		|=> out_q == ERASE_READ)
		else $error("serial read during erase not zero");
	a_write_len: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(op_q == OP_WRITE) |-> tmr_q == TW'(WRITE_CYCLES - 1))
		else $error("write timer not loaded");
	a_ser_enable: assert property (@(posedge pclk) disable iff (!presetn)
		!dev_rst |=> !ser_en_q)
		else $error("serial enable kept outside reset");
endmodule : fplc_top

// ### rtl/fplc_pkg.sv
// Shared constants and types of the flash program and lock controller
package fplc_pkg;
	// ==========================================================
	// Array and timing
	localparam int unsigned CODE_BYTES = 12288;
	localparam logic [13:0] CODE_LAST = 14'h2fff;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [7:0] ERASE_READ = 8'h00;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned T_WRITE_NS = 1500000;
	localparam int unsigned T_SER_ERASE_NS = 16000000;
	localparam int unsigned T_PAR_ERASE_NS = 10000000;
	localparam int unsigned WRITE_CYC = T_WRITE_NS / CLK_PERIOD_NS;
	localparam int unsigned SER_ERASE_CYC = T_SER_ERASE_NS / CLK_PERIOD_NS;
	localparam int unsigned PAR_HOLD_CYC = (T_PAR_ERASE_NS
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TW = 22;
	// ==========================================================
	// Signature (values arbitrary)
	localparam logic [13:0] SIG_ADDR0 = 14'h0030;
	localparam logic [13:0] SIG_ADDR1 = 14'h0031;
	localparam logic [7:0] SIG_BYTE0 = 8'h5a;
	localparam logic [7:0] SIG_BYTE1 = 8'ha5;
	// ==========================================================
	// Parallel mode codes {a, verify, c, d}
	localparam logic [3:0] PM_ERASE = 4'h8;
	localparam logic [3:0] PM_WRITE = 4'h7;
	localparam logic [3:0] PM_READ = 4'h3;
	localparam logic [3:0] PM_SIG = 4'h0;
	localparam logic [3:0] PM_WLOCK = 4'ha;
	localparam logic [3:0] PM_RLOCK = 4'hc;
	localparam logic [3:0] PM_FUSE = 4'h5;
	// Lock bit positions on the data lines
	localparam int unsigned LB1_POS = 7;
	localparam int unsigned LB2_POS = 6;
	localparam int unsigned LB3_POS = 5;
	localparam int unsigned RLB1_POS = 2;
	localparam int unsigned RLB2_POS = 1;
	// ==========================================================
	// Serial instruction bytes
	localparam logic [7:0] SI_PREFIX = 8'hac;
	localparam logic [7:0] SI_ENABLE = 8'h53;
	localparam logic [2:0] SI_ERASE = 3'h4;
	localparam logic [2:0] SI_WLOCK = 3'h7;
	localparam logic [1:0] SI_READ = 2'h1;
	localparam logic [1:0] SI_WRITE = 2'h2;
	localparam logic [4:0] SI_LAST_BIT = 5'h17;
	localparam logic [4:0] SI_OUT_BIT = 5'h10;
	// ==========================================================
	// APB map
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_CTRL = 12'h004;
	// ==========================================================
	typedef struct packed {
		logic a;
		logic verify;
		logic c;
		logic d;
	} fplc_msel_t;
	typedef enum logic [2:0] {
		OP_IDLE, OP_WRITE, OP_LOCK, OP_FUSE, OP_ERASE
	} fplc_op_t;
endpackage : fplc_pkg

// ### tb/fplc_prog.sv
// Programmer model driving the parallel and serial programming pins
`timescale 1ns/1ps
module fplc_prog
	import fplc_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Parallel pins
	output logic dev_rst,
	output logic par_enable,
	output logic external_access_pin,
	output fplc_msel_t msel,
	output logic prog_strobe_n,
	output logic [13:0] par_addr,
	output logic [7:0] par_din,
	input wire logic [7:0] par_dout,
	input wire logic par_dout_oe,
	// Serial pins
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	initial begin
		dev_rst = 1'b1;
		par_enable = 1'b0;
		external_access_pin = 1'b1;
		msel = PM_READ;
		prog_strobe_n = 1'b1;
		par_addr = 14'h0000;
		par_din = 8'h00;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// ==========================================================
	// Parallel strobe; lo cycles low, long enough for erase
	task pulse(input logic [3:0] m, input logic [13:0] a,
		input logic [7:0] d, input int lo);
		@(posedge pclk);
		par_enable <= 1'b1;
		msel <= m;
		par_addr <= a;
		par_din <= d;
		@(posedge pclk);
		prog_strobe_n <= 1'b0;
		repeat (lo) @(posedge pclk);
		prog_strobe_n <= 1'b1;
	endtask : pulse
	// Data lines flipped while released, so stale values never match
	task pread(input logic [3:0] m, input logic [13:0] a,
		output logic [7:0] d, output logic oe);
		@(posedge pclk);
		par_enable <= 1'b1;
		msel <= m;
		par_addr <= a;
		par_din <= ~par_din;
		repeat (3) @(posedge pclk);
		d = par_dout;
		oe = par_dout_oe;
	endtask : pread
	// Device reset pin low a few cycles; serial enable is lost
	task rst_cycle;
		@(posedge pclk);
		dev_rst <= 1'b0;
		repeat (4) @(posedge pclk);
		dev_rst <= 1'b1;
	endtask : rst_cycle
	// ==========================================================
	// Serial frame, mode 0; sck stands low between frames
	task ser(input logic [23:0] f, output logic [7:0] r);
		@(posedge pclk);
		par_enable <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			mosi <= f[i];
			repeat (40) @(posedge pclk);
			sck <= 1'b1;
			if (i < 8)
				r[i] = miso;
			repeat (40) @(posedge pclk);
			sck <= 1'b0;
		end
	endtask : ser
endmodule : fplc_prog

// ### tb/testbench.sv
// Self-checking bench for the flash program and lock controller
`timescale 1ns/1ps
module testbench;
	import fplc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic dev_rst, par_enable, ea, stb_n, par_dout_oe, rb, sck, mosi;
	logic miso, trb, xeb;
	fplc_msel_t msel;
	logic [13:0] par_addr, a;
	logic [7:0] par_din, par_dout, d, q;
	int failures, checks_done;
	fplc_top #(.WRITE_CYCLES(20), .SER_ERASE_CYCLES(20),
		.PAR_HOLD_CYCLES(10)) fplc_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dev_rst(dev_rst), .par_enable(par_enable),
		.external_access_pin(ea), .msel(msel), .prog_strobe_n(stb_n),
		.par_addr(par_addr), .par_din(par_din), .par_dout(par_dout),
		.par_dout_oe(par_dout_oe), .ready_busy_output(rb), .sck(sck),
		.mosi(mosi), .miso(miso), .table_read_block(trb),
		.ext_exec_block(xeb));
	fplc_prog fplc_prog_i (.pclk(pclk), .dev_rst(dev_rst),
		.par_enable(par_enable), .external_access_pin(ea), .msel(msel),
		.prog_strobe_n(stb_n), .par_addr(par_addr), .par_din(par_din),
		.par_dout(par_dout), .par_dout_oe(par_dout_oe), .sck(sck),
		.mosi(mosi), .miso(miso));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ==========================================================
	// Expectations
	function automatic logic [7:0] poll(input logic [7:0] v);
		return {~v[7], v[6:0]};
	endfunction : poll
	function automatic logic [23:0] sw(input logic [13:0] x,
		input logic [7:0] v);
		return {x[13:8], SI_WRITE, x[7:0], v};
	endfunction : sw
	function automatic logic [23:0] sr(input logic [13:0] x);
		return {x[13:8], SI_READ, x[7:0], 8'h00};
	endfunction : sr
	// ==========================================================
	// Checks and bus cycles
	task summarize;
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[4:3] !== 2'b00 && n < 20000);
		if (n >= 20000) begin
			failures++;
			summarize();
		end
	endtask : idle
	task wrdy;
		int n;
		n = 0;
		while (rb !== 1'b1 && n < 60) begin
			@(posedge pclk);
			n++;
		end
		chk(rb, 1'b1);
	endtask : wrdy
	// ==========================================================
	initial begin
		repeat (95000) @(posedge pclk);
		failures++;
		summarize();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		failures = 0;
		checks_done = 0;
		void'($urandom(32'h4c57));
		repeat (6) @(posedge pclk);
		chk(rb, 1'b1);
		presetn <= 1'b1;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[2:0], 3'b000);
		chk(rd[6], 1'b0);
		apb(1'b0, 12'h008, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd[0], 1'b1);
		fplc_prog_i.pulse(PM_ERASE, 14'h0, 8'h0, 12);
		idle();
		a = 14'($urandom % CODE_BYTES);
		fplc_prog_i.pread(PM_READ, a, q, oe);
		chk(q, ERASED);
		// Serial rewrite relies on auto-erase: second byte is ~first
		fplc_prog_i.ser({SI_PREFIX, SI_ENABLE, 8'h00}, q);
		d = 8'($urandom);
		fplc_prog_i.ser(sw(14'h0, d), q);
		idle();
		d = ~d;
		fplc_prog_i.ser(sw(14'h0, d), q);
		idle();
		fplc_prog_i.ser(sr(14'h0), q);
		chk(q, d);
		for (int i = 1; i <= 3; i++) begin
			a = (i == 3) ? CODE_LAST : 14'(i * 256 + $urandom % 256);
			d = 8'($urandom);
			fplc_prog_i.pulse(PM_WRITE, a, d, 2);
			repeat (3) @(posedge pclk);
			chk(rb, 1'b0);
			fplc_prog_i.pread(PM_READ, a, q, oe);
			chk(q, poll(d));
			wrdy();
			fplc_prog_i.pread(PM_READ, a, q, oe);
			chk(q, d);
		end
		fplc_prog_i.pread(PM_SIG, SIG_ADDR0, q, oe);
		chk(q, SIG_BYTE0);
		fplc_prog_i.pread(PM_SIG, SIG_ADDR1, q, oe);
		chk(q, SIG_BYTE1);
		fplc_prog_i.pulse(PM_WLOCK, 14'h0, 8'h7f, 2);
		idle();
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[2:0], 3'b001);
		chk(rd[5], 1'b1);
		chk(trb, 1'b1);
		fplc_prog_i.pread(PM_RLOCK, 14'h0, q, oe);
		chk(q[2:1], 2'b01);
		fplc_prog_i.pulse(PM_WRITE, 14'h0010, 8'h00, 2);
		repeat (3) @(posedge pclk);
		chk(rb, 1'b1);
		fplc_prog_i.pread(PM_READ, 14'h0010, q, oe);
		chk(q, ERASED);
		fplc_prog_i.pulse(PM_ERASE, 14'h0, 8'h0, 12);
		idle();
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[2:0], 3'b000);
		fplc_prog_i.pulse(PM_WLOCK, 14'h0, 8'h1f, 2);
		idle();
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[2:0], 3'b111);
		chk(xeb, 1'b1);
		fplc_prog_i.pread(PM_READ, CODE_LAST, q, oe);
		chk(oe, 1'b0);
		fplc_prog_i.pulse(PM_ERASE, 14'h0, 8'h0, 12);
		idle();
		// Without a fresh enable after reset the write is dropped
		fplc_prog_i.rst_cycle();
		fplc_prog_i.ser(sw(14'h0020, 8'h00), q);
		idle();
		fplc_prog_i.pread(PM_READ, 14'h0020, q, oe);
		chk(q, ERASED);
		fplc_prog_i.ser({SI_PREFIX, SI_ENABLE, 8'h00}, q);
		fplc_prog_i.ser({SI_PREFIX, 5'h00, SI_ERASE, 8'h00}, q);
		fplc_prog_i.ser(sr(CODE_LAST), q);
		chk(q, ERASE_READ);
		idle();
		fplc_prog_i.pread(PM_READ, 14'h0, q, oe);
		chk(q, ERASED);
		fplc_prog_i.pulse(PM_FUSE, 14'h0, 8'h01, 2);
		idle();
		fplc_prog_i.rst_cycle();
		fplc_prog_i.ser({SI_PREFIX, SI_ENABLE, 8'h00}, q);
		fplc_prog_i.ser(sw(14'h0005, 8'h00), q);
		idle();
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[7:6], 2'b01);
		fplc_prog_i.pread(PM_READ, 14'h0005, q, oe);
		chk(q, ERASED);
		summarize();
	end
endmodule : testbench
